// file: hw/rlie_defines.svh
// constants for the return and literal instruction executor
`ifndef RLIE_DEFINES_SVH
`define RLIE_DEFINES_SVH
`define RLIE_OPC_RETURN_FROM_IRQ 14'h0009
`define RLIE_OPC_OPTION_LOAD 14'h0062
`define RLIE_RET_LIT_TOP 4'hD
`define RLIE_RET_LIT_MSB 13
`define RLIE_RET_LIT_LSB 10
`define RLIE_IRQ_CTRL_RST 8'h00
`define RLIE_OPTION_RST 8'hFF
`define RLIE_ACC_RST 8'h00
`define RLIE_IRQ_EN_POS 7
`endif

// file: hw/rlie_pkg.sv
// types for the return and literal instruction executor
package rlie_pkg;
	typedef enum logic [2:0] {
		RLIE_IDLE = 3'b001,
		RLIE_POP = 3'b010,
		RLIE_LOAD = 3'b100
	} rlie_state_type;
	typedef enum logic [2:0] {
		RLIE_OP_NONE = 3'b000,
		RLIE_OP_RETFI = 3'b001,
		RLIE_OP_RETLIT = 3'b010,
		RLIE_OP_OPT = 3'b100
	} rlie_op_type;
	typedef struct packed {
		logic valid;
		logic [13:0] word;
	} rlie_instr_type;
	typedef struct packed {
		logic pop;
		logic [12:0] pc;
		logic pc_load;
	} rlie_flow_type;
endpackage

// file: hw/rlie_decode.sv
// opcode classifier for the return and literal instructions
`timescale 1ns/1ps
`include "rlie_defines.svh"
module rlie_decode (
	input wire logic [13:0] word_i,
	output rlie_pkg::rlie_op_type op_o
);
	always_comb begin
		if (word_i == `RLIE_OPC_RETURN_FROM_IRQ) begin
			op_o = rlie_pkg::RLIE_OP_RETFI;
		end else if (word_i[`RLIE_RET_LIT_MSB:`RLIE_RET_LIT_LSB] ==
			`RLIE_RET_LIT_TOP) begin
			op_o = rlie_pkg::RLIE_OP_RETLIT;
		end else if (word_i == `RLIE_OPC_OPTION_LOAD) begin
			op_o = rlie_pkg::RLIE_OP_OPT;
		end else begin
			op_o = rlie_pkg::RLIE_OP_NONE;
		end
	end
endmodule // rlie_decode

// file: hw/rlie_exec.sv
// execution of return-from-irq, return-with-literal and option load
`timescale 1ns/1ps
`include "rlie_defines.svh"
module rlie_exec #(
	parameter int PC_WIDTH = 13
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input rlie_pkg::rlie_instr_type instr_i,
	input wire logic [PC_WIDTH-1:0] stack_top_entry_i,
	input wire logic [7:0] acc_wr_i,
	input wire logic acc_wr_en_i,
	output logic busy_o,
	output logic stack_pop_o,
	output logic pc_load_o,
	output logic [PC_WIDTH-1:0] pc_o,
	output logic [7:0] acc_o,
	output logic [7:0] option_o,
	output logic [7:0] interrupt_control_reg_o,
	output logic global_irq_enable_bit_o,
	output logic status_we_o
);
	// ***********************************************
	// decode
	// ***********************************************
	rlie_pkg::rlie_op_type op;
	logic take;
	rlie_decode u_dec (
		.word_i(instr_i.word),
		.op_o(op)
	);
	// ***********************************************
	// helpers
	// ***********************************************
	// both returns share the pop cycle
	function automatic logic is_return(input rlie_pkg::rlie_op_type o);
		return (o == rlie_pkg::RLIE_OP_RETFI) ||
			(o == rlie_pkg::RLIE_OP_RETLIT);
	endfunction
	// ***********************************************
	// state
	// ***********************************************
	rlie_pkg::rlie_state_type state_reg, state_next;
	logic [PC_WIDTH-1:0] pc_reg, pc_next;
	logic [7:0] acc_reg, acc_next;
	logic [7:0] opt_reg, opt_next;
	logic [7:0] ictl_reg, ictl_next;
	logic pop_reg, pop_next;
	logic pcl_reg, pcl_next;
	assign take = instr_i.valid && (state_reg == rlie_pkg::RLIE_IDLE);
	assign busy_o = (state_reg != rlie_pkg::RLIE_IDLE);
	assign status_we_o = 1'b0;
	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		acc_next = acc_reg;
		opt_next = opt_reg;
		ictl_next = ictl_reg;
		pop_next = 1'b0;
		pcl_next = 1'b0;
		if (acc_wr_en_i) begin
			acc_next = acc_wr_i;
		end
		case (state_reg)
			rlie_pkg::RLIE_IDLE: begin
				if (take) begin
					case (op)
						rlie_pkg::RLIE_OP_RETFI: begin
							state_next = rlie_pkg::RLIE_POP;
							ictl_next[`RLIE_IRQ_EN_POS] = 1'b1;
						end
						rlie_pkg::RLIE_OP_RETLIT: begin
							state_next = rlie_pkg::RLIE_POP;
							acc_next = instr_i.word[7:0];
						end
						rlie_pkg::RLIE_OP_OPT: begin
							opt_next = acc_reg;
						end
						default: begin
						end
					endcase
				end
			end
			rlie_pkg::RLIE_POP: begin
				// second cycle: pop and reload pc
				pop_next = 1'b1;
				pcl_next = 1'b1;
				pc_next = stack_top_entry_i;
				// pop cycle is the second and last one
				state_next = rlie_pkg::RLIE_IDLE;
			end
			default: begin
				state_next = rlie_pkg::RLIE_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg <= rlie_pkg::RLIE_IDLE;
			pc_reg <= '0;
			acc_reg <= `RLIE_ACC_RST;
			opt_reg <= `RLIE_OPTION_RST;
			ictl_reg <= `RLIE_IRQ_CTRL_RST;
			pop_reg <= 1'b0;
			pcl_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			acc_reg <= acc_next;
			opt_reg <= opt_next;
			ictl_reg <= ictl_next;
			pop_reg <= pop_next;
			pcl_reg <= pcl_next;
		end
	end
	assign stack_pop_o = pop_reg;
	assign pc_load_o = pcl_reg;
	assign pc_o = pc_reg;
	assign acc_o = acc_reg;
	assign option_o = opt_reg;
	assign interrupt_control_reg_o = ictl_reg;
	assign global_irq_enable_bit_o = ictl_reg[`RLIE_IRQ_EN_POS];
	// ***********************************************
	// assertions
	// ***********************************************
	// return from irq, then pop, pc, status and busy checks common to all instructions
	a_retfi_pops: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		take && op == rlie_pkg::RLIE_OP_RETFI
		|-> ##2 stack_pop_o && pc_load_o)
		else $error("return from irq did not pop");
	a_retfi_pc: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		take && op == rlie_pkg::RLIE_OP_RETFI
		|=> ##1 pc_o == $past(stack_top_entry_i))
		else $error("return from irq pc not reloaded");
	a_pop_pulse: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		stack_pop_o
		|=> !stack_pop_o)
		else $error("stack pop longer than one cycle");
	a_pc_hold: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		!pc_load_o
		|-> $stable(pc_o))
		else $error("pc moved without a load");
	a_retfi_gie: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		take && op == rlie_pkg::RLIE_OP_RETFI
		|=> global_irq_enable_bit_o)
		else $error("global enable not set");
	a_ictl_hold: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		!(take && op == rlie_pkg::RLIE_OP_RETFI)
		|=> $stable(interrupt_control_reg_o))
		else $error("interrupt control changed without return");
	a_two_cycle: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		take && op == rlie_pkg::RLIE_OP_RETFI
		|=> busy_o ##1 !busy_o)
		else $error("return from irq wrong length");
	a_no_status: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		!status_we_o)
		else $error("status written");
	a_busy_refuse: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		busy_o
		|=> !busy_o && $stable(option_o))
		else $error("instruction taken while busy");
	// return with literal
	a_lit_load: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		take && op == rlie_pkg::RLIE_OP_RETLIT
		|=> acc_o == $past(instr_i.word[7:0]))
		else $error("literal not loaded");
	a_lit_pops: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		take && op == rlie_pkg::RLIE_OP_RETLIT
		|-> ##2 stack_pop_o && pc_load_o)
		else $error("return with literal did not pop");
	a_lit_pc: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		take && op == rlie_pkg::RLIE_OP_RETLIT
		|=> ##1 pc_o == $past(stack_top_entry_i))
		else $error("pc not reloaded from stack");
	a_lit_len: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		take && op == rlie_pkg::RLIE_OP_RETLIT
		|=> busy_o ##1 !busy_o)
		else $error("return with literal wrong length");
	// option load
	a_opt_copy: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		take && op == rlie_pkg::RLIE_OP_OPT
		|=> option_o == $past(acc_o) && !busy_o)
		else $error("option not loaded");
	a_opt_hold: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		!(take && op == rlie_pkg::RLIE_OP_OPT)
		|=> $stable(option_o))
		else $error("option changed without option load");
	// ***********************************************
	// covers
	// ***********************************************
	c_retfi: cover property (@(posedge clk_i)
		take && op == rlie_pkg::RLIE_OP_RETFI);
	c_retlit: cover property (@(posedge clk_i)
		take && op == rlie_pkg::RLIE_OP_RETLIT);
	c_opt: cover property (@(posedge clk_i)
		take && op == rlie_pkg::RLIE_OP_OPT);
	c_refused: cover property (@(posedge clk_i)
		busy_o && instr_i.valid);
	c_ret_back: cover property (@(posedge clk_i)
		take && is_return(op) ##2 take && is_return(op));
endmodule // rlie_exec

// file: verif/rlie_exec_tb.sv
// self-checking bench for the return and literal executor
`timescale 1ns/1ps
module rlie_exec_tb;
	logic clk_i = 0;
	logic sys_rst_i = 1;
	rlie_pkg::rlie_instr_type instr_i = '0;
	logic [12:0] stk = 13'h0000;
	logic [7:0] acc_wr_i = 8'h00;
	logic acc_wr_en_i = 0;
	logic busy_o, stack_pop_o, pc_load_o, gie_o, status_we_o;
	logic [12:0] pc_o;
	logic [7:0] acc_o, option_o, irq_o, rnd, lit;
	int failures = 0;
	int comparisons = 0;
	logic [12:0] pc_q[$];
	rlie_exec i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i),
		.stack_top_entry_i(stk), .acc_wr_i(acc_wr_i),
		.acc_wr_en_i(acc_wr_en_i), .busy_o(busy_o),
		.stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
		.acc_o(acc_o), .option_o(option_o), .interrupt_control_reg_o(irq_o),
		.global_irq_enable_bit_o(gie_o), .status_we_o(status_we_o));
	// ****
	// helpers
	// ****
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task chk_pc(input string what, input logic [12:0] e, input logic [12:0] g);
		comparisons++;
		if (e !== g) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (e !== g) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task conclude;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task issue(input logic [13:0] w);
		@(negedge clk_i);
		instr_i.valid = 1'b1;
		instr_i.word = w;
		@(negedge clk_i);
		instr_i.valid = 1'b0;
	endtask
	// ****
	// stimulus
	// ****
	initial forever #50 clk_i = ~clk_i;
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		conclude();
	end
	always @(negedge clk_i) begin
		chk_byte("flags", 8'h00, {7'h00, status_we_o});
		if (!sys_rst_i && pc_load_o === 1'b1) begin
			if (pc_q.size() == 0)
				chk_pc("pc pulse", 13'h0000, 13'h0001);
			else
				chk_pc("pc", pc_q.pop_front(), pc_o);
			chk_byte("pop", 8'h01, {7'h00, stack_pop_o});
		end
	end
	initial begin
		rnd = 8'h1C;
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		sys_rst_i = 0;
		chk_byte("option rst", 8'hFF, option_o);
		// return from irq, then a literal offered while busy
		rnd = lfsr(rnd);
		stk = {5'h15, rnd};
		pc_q.push_back(stk);
		@(negedge clk_i);
		instr_i.valid = 1'b1;
		instr_i.word = 14'h0009;
		@(negedge clk_i);
		instr_i.word = 14'h34AB;
		chk_byte("irq ctrl", 8'h80, irq_o);
		chk_byte("gie", 8'h01, {7'h00, gie_o});
		chk_byte("busy", 8'h01, {7'h00, busy_o});
		@(negedge clk_i);
		instr_i.valid = 1'b0;
		chk_byte("refused", 8'h00, acc_o);
		chk_byte("busy over", 8'h00, {7'h00, busy_o});
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			lit = rnd;
			rnd = lfsr(rnd);
			stk = {rnd[4:0], ~lit};
			pc_q.push_back(stk);
			acc_wr_i = ~lit;
			acc_wr_en_i = 1'b1;
			issue({4'hD, rnd[7:6], lit});
			acc_wr_en_i = 1'b0;
			chk_byte("acc", lit, acc_o);
			chk_byte("busy lit", 8'h01, {7'h00, busy_o});
			@(negedge clk_i);
			chk_byte("busy end", 8'h00, {7'h00, busy_o});
		end
		acc_wr_i = 8'h5A;
		acc_wr_en_i = 1'b1;
		@(negedge clk_i);
		acc_wr_en_i = 1'b0;
		issue(14'h0062);
		chk_byte("option", 8'h5A, option_o);
		chk_byte("no busy", 8'h00, {7'h00, busy_o});
		// reset again in mid-run
		sys_rst_i = 1;
		repeat (2) @(negedge clk_i);
		sys_rst_i = 0;
		chk_byte("acc rst", 8'h00, acc_o);
		chk_byte("option rst again", 8'hFF, option_o);
		chk_byte("irq rst", 8'h00, irq_o);
		chk_pc("pc rst", 13'h0000, pc_o);
		repeat (3) @(negedge clk_i);
		chk_pc("pending", 13'h0000, 13'(pc_q.size()));
		conclude();
	end
endmodule // rlie_exec_tb
